// [rtl/lwr_pkg.sv]
package lwr_pkg;
  // ==========================================
  // register offsets (byte addresses on the serial management bus)
  localparam logic [7:0] RX_CTRL_OFFSET = 8'h23;
  localparam logic [7:0] LOCK_EVT_OFFSET = 8'h24;
  localparam logic [7:0] HARD_LOCK_OFFSET = 8'h25;
  localparam logic [7:0] CTRL_SCRATCH_OFFSET = 8'h26;
  // ==========================================
  // field positions
  localparam int LOCK_BIT = 0;
  localparam int LOSS_BIT = 1;
  localparam int TERM_BIT = 0;
  localparam int BIAS_BIT = 1;
  localparam int HARD_LOCK_BIT = 0;
  // ==========================================
  // reset values
  localparam logic [7:0] LOCK_EVT_RESET = 8'h00;
  localparam logic [7:0] RX_CTRL_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [7:0] HARD_LOCK_RESET = 8'h00;
endpackage

// [rtl/lwr_sync2.sv]
`timescale 1ns/1ps
module lwr_sync2 #(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_r;

  // the first stage feeds only the second
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      stage1_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1_r <= async_in;
      sync_out <= stage1_r;
    end
  end
endmodule

// [rtl/lwr_regs.sv]
// Operation
// - loss detector event sets the sticky flag, bit 1, until software clears it
// - flag reads zero after clear; write one clears it, zero leaves it
// - writing one to bit 0 while clear engages lock; control writes ignored
// - writing one to bit 0 while locked releases it; lock resets unlocked
// - self-bias bit, byte 35 bit 1, enables internal input bias network
// - termination bit, byte 35 bit 0, enables pull-downs on both legs
// - each clock input gets its own self-bias and termination bit
// - starts with input running, floating or low/low; idles without clock
// - loss event comes from the clock presence detector on the input pair
// - separate power-cycle-only lock also blocks control writes
`timescale 1ns/1ps
module lwr_regs #(
  parameter int NUM_INPUTS = 1
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register access from the bus engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_ack,
  // loss detector, one level per input
  input wire logic [NUM_INPUTS-1:0] loss_detect,
  // receiver configuration
  output logic [NUM_INPUTS-1:0] input_self_bias_en,
  output logic [NUM_INPUTS-1:0] input_term_en,
  // lock state
  output logic write_blocked,
  output logic [7:0] ctrl_scratch
);
  // ==========================================
  // elaboration check
  // receiver bytes sit below the lock byte; more inputs would overlap it
  localparam int RX_ROOM = int'(lwr_pkg::LOCK_EVT_OFFSET - lwr_pkg::RX_CTRL_OFFSET);

  if (NUM_INPUTS < 1 || NUM_INPUTS > RX_ROOM)
  begin : g_bad
    $error("NUM_INPUTS must leave receiver bytes below the lock register");
  end

  // ==========================================
  // loss detector crossing
  logic [NUM_INPUTS-1:0] loss_sync;
  logic [NUM_INPUTS-1:0] loss_prev_r;
  logic [NUM_INPUTS-1:0] loss_edge;
  logic loss_rise;

  lwr_sync2 #(.WIDTH(NUM_INPUTS)) u_loss_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(loss_detect),
    .sync_out(loss_sync)
  );

  // edge, not level: a clear sticks while the input stays lost
  genvar li;
  for (li = 0; li < NUM_INPUTS; li++)
  begin : g_loss
    always_ff @(posedge ref_clk)
    begin
      if (sys_rst)
        loss_prev_r[li] <= 1'h0;
      else
        loss_prev_r[li] <= loss_sync[li];
    end

    assign loss_edge[li] = loss_sync[li] & ~loss_prev_r[li];
  end

  // prev resets low, so a loss already present at start counts once
  assign loss_rise = |loss_edge;

  // ==========================================
  // decode
  logic wr_evt;
  logic wr_rx;
  logic wr_hard;
  logic wr_scr;
  logic clr_loss;
  logic flip_lock;
  logic set_hard;
  logic hard_lock_r;
  logic loss_event_sticky_r;
  logic clearable_write_inhibit_r;

  // never blocked, else a locked part could not be unlocked or cleared
  assign wr_evt = reg_wr && reg_addr == lwr_pkg::LOCK_EVT_OFFSET;
  assign clr_loss = wr_evt && reg_wdata[lwr_pkg::LOSS_BIT];
  assign flip_lock = wr_evt && reg_wdata[lwr_pkg::LOCK_BIT];
  // either lock blocks control writes; reads always served
  assign write_blocked = clearable_write_inhibit_r | hard_lock_r;
  assign wr_rx = reg_wr && !write_blocked
    && reg_addr >= lwr_pkg::RX_CTRL_OFFSET
    && reg_addr < lwr_pkg::RX_CTRL_OFFSET + 8'(NUM_INPUTS);
  assign wr_hard = reg_wr && !write_blocked && reg_addr == lwr_pkg::HARD_LOCK_OFFSET;
  assign wr_scr = reg_wr && !write_blocked && reg_addr == lwr_pkg::CTRL_SCRATCH_OFFSET;
  assign set_hard = wr_hard && reg_wdata[lwr_pkg::HARD_LOCK_BIT];

  // ==========================================
  // sticky loss flag; set wins over a clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      loss_event_sticky_r <= lwr_pkg::LOCK_EVT_RESET[lwr_pkg::LOSS_BIT];
    else if (loss_rise)
      loss_event_sticky_r <= 1'h1;
    else if (clr_loss)
      loss_event_sticky_r <= 1'h0;
  end

  // ==========================================
  // clearable lock toggles on a written one
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      clearable_write_inhibit_r <= lwr_pkg::LOCK_EVT_RESET[lwr_pkg::LOCK_BIT];
    else if (flip_lock)
      clearable_write_inhibit_r <= ~clearable_write_inhibit_r;
  end

  // ==========================================
  // power-cycle lock: only reset clears it
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      hard_lock_r <= lwr_pkg::HARD_LOCK_RESET[lwr_pkg::HARD_LOCK_BIT];
    else if (set_hard)
      hard_lock_r <= 1'h1;
  end

  // ==========================================
  // receiver configuration, one byte per input
  logic [NUM_INPUTS-1:0] self_bias_r;
  logic [NUM_INPUTS-1:0] term_r;

  assign input_self_bias_en = self_bias_r;
  assign input_term_en = term_r;

  genvar gi;
  for (gi = 0; gi < NUM_INPUTS; gi++)
  begin : g_rx
    always_ff @(posedge ref_clk)
    begin
      if (sys_rst)
      begin
        self_bias_r[gi] <= lwr_pkg::RX_CTRL_RESET[lwr_pkg::BIAS_BIT];
        term_r[gi] <= lwr_pkg::RX_CTRL_RESET[lwr_pkg::TERM_BIT];
      end
      else if (wr_rx && reg_addr == lwr_pkg::RX_CTRL_OFFSET + 8'(gi))
      begin
        self_bias_r[gi] <= reg_wdata[lwr_pkg::BIAS_BIT];
        term_r[gi] <= reg_wdata[lwr_pkg::TERM_BIT];
      end
    end
  end

  // ==========================================
  // plain control byte, lets software see lock effect
  logic [7:0] ctrl_scratch_r;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      ctrl_scratch_r <= lwr_pkg::SCRATCH_RESET;
    else if (wr_scr)
      ctrl_scratch_r <= reg_wdata;
  end

  assign ctrl_scratch = ctrl_scratch_r;

  // ==========================================
  // read path, registered; unmapped reads zero
  logic [7:0] rdata_nxt;
  logic [7:0] rx_idx;
  logic [7:0] reg_rdata_r;
  logic reg_ack_r;

  always_comb
  begin
    rdata_nxt = 8'h00;
    rx_idx = reg_addr - lwr_pkg::RX_CTRL_OFFSET;
    if (reg_addr == lwr_pkg::LOCK_EVT_OFFSET)
    begin
      rdata_nxt[lwr_pkg::LOSS_BIT] = loss_event_sticky_r;
      rdata_nxt[lwr_pkg::LOCK_BIT] = clearable_write_inhibit_r;
    end
    else if (reg_addr == lwr_pkg::HARD_LOCK_OFFSET)
      rdata_nxt[lwr_pkg::HARD_LOCK_BIT] = hard_lock_r;
    else if (reg_addr == lwr_pkg::CTRL_SCRATCH_OFFSET)
      rdata_nxt = ctrl_scratch_r;
    else
    begin
      // addresses below the receiver bytes wrap high and match no input
      for (int i = 0; i < NUM_INPUTS; i++)
      begin
        if (rx_idx == 8'(i))
        begin
          rdata_nxt[lwr_pkg::BIAS_BIT] = self_bias_r[i];
          rdata_nxt[lwr_pkg::TERM_BIT] = term_r[i];
        end
      end
    end
  end

  // data holds between reads; ack pulses for every strobe, refused or not
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      reg_rdata_r <= 8'h00;
    else if (reg_rd)
      reg_rdata_r <= rdata_nxt;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      reg_ack_r <= 1'h0;
    else
      reg_ack_r <= reg_rd | reg_wr;
  end

  assign reg_rdata = reg_rdata_r;
  assign reg_ack = reg_ack_r;
endmodule

// [dv/lwr_regs_checker.sv]
`timescale 1ns/1ps
// ==========
// register bank checker
module lwr_regs_checker #(
  parameter int NUM_INPUTS = 1
)
(
  // clock and reset
  input logic ref_clk,
  input logic sys_rst,
  // bus
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic reg_ack,
  // receiver and lock
  input logic [NUM_INPUTS-1:0] loss_detect,
  input logic [NUM_INPUTS-1:0] input_self_bias_en,
  input logic [NUM_INPUTS-1:0] input_term_en,
  input logic write_blocked,
  input logic [7:0] ctrl_scratch
);
  logic w_ev, w_rx, w_sc;
  assign w_ev = reg_wr && reg_addr == lwr_pkg::LOCK_EVT_OFFSET;
  assign w_rx = reg_wr && reg_addr == lwr_pkg::RX_CTRL_OFFSET;
  assign w_sc = reg_wr && reg_addr == lwr_pkg::CTRL_SCRATCH_OFFSET;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_ack_follows: assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("no ack");
  a_lock_engage: assert property (w_ev && reg_wdata[0] && !write_blocked |=> write_blocked)
    else $error("lock not engaged");
  a_scratch_hold: assert property (write_blocked && w_sc |=> $stable(ctrl_scratch))
    else $error("blocked write landed");
  a_scratch_take: assert property (
    !write_blocked && w_sc |=> ctrl_scratch == $past(reg_wdata))
    else $error("write lost");
  a_bias_take: assert property (
    !write_blocked && w_rx |=> input_self_bias_en[0] == $past(reg_wdata[1]))
    else $error("bias bit");
  a_term_take: assert property (
    !write_blocked && w_rx |=> input_term_en[0] == $past(reg_wdata[0]))
    else $error("term bit");
  a_rx_hold: assert property (
    write_blocked && w_rx |=> $stable(input_self_bias_en) && $stable(input_term_en))
    else $error("blocked receiver write landed");
  a_rsv_zero: assert property (
    reg_rd && reg_addr == lwr_pkg::LOCK_EVT_OFFSET |=> reg_rdata[7:2] == 6'h00)
    else $error("reserved bits");
  a_hard_hold: assert property (
    !write_blocked && reg_wr && reg_addr == lwr_pkg::HARD_LOCK_OFFSET && reg_wdata[0]
    |=> write_blocked [*8])
    else $error("hard lock dropped");
endmodule

// [dv/lwr_los_model.sv]
`timescale 1ns/1ps
// ==========
// clock presence detector model
module lwr_los_model
(
  input logic clk_on,
  output logic loss_detect
);
  // odd skew keeps the level unrelated to the bus clock edge
  assign #37 loss_detect = ~clk_on;
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] RX = lwr_pkg::RX_CTRL_OFFSET;
  localparam logic [7:0] EV = lwr_pkg::LOCK_EVT_OFFSET;
  localparam logic [7:0] HL = lwr_pkg::HARD_LOCK_OFFSET;
  localparam logic [7:0] SC = lwr_pkg::CTRL_SCRATCH_OFFSET;
  logic ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, clk_on = 1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ctrl_scratch, sc;
  logic reg_ack, write_blocked, loss_detect, input_self_bias_en, input_term_en;
  logic [7:0] pr[3] = '{8'h02, 8'h01, 8'h00};
  logic [8:0] q[$];
  logic [8:0] e;
  int errors = 0, tests_run = 0, cyc = 0, seed = 87450;
  always #50 ref_clk = ~ref_clk;
  lwr_regs u_lwr_regs (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .loss_detect(loss_detect), .input_self_bias_en(input_self_bias_en),
    .input_term_en(input_term_en), .write_blocked(write_blocked), .ctrl_scratch(ctrl_scratch));
  lwr_los_model u_lwr_los_model (.clk_on(clk_on), .loss_detect(loss_detect));
  task chk(input logic [7:0] g, x);
    tests_run++;
    if (g !== x)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // one access; reads note the expected data
  task acc(input logic w, input logic [7:0] a, d, x);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    q.push_back({!w, x});
    @(posedge ref_clk);
    reg_wr <= 0;
    reg_rd <= 0;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      results();
    end
    else if (reg_ack === 1'b1)
    begin
      e = q.pop_front();
      if (e[8])
        chk(reg_rdata, e[7:0]);
    end
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 0;
    acc(0, EV, 0, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      acc(1, RX, pr[i], 0);
      @(posedge ref_clk);
      chk({6'h00, input_self_bias_en, input_term_en}, pr[i]);
      acc(0, RX, 0, pr[i]);
    end
    $display("done: receiver config");
    sc = 8'($random(seed));
    acc(1, SC, sc, 0);
    acc(1, EV, 8'h01, 0);
    acc(1, SC, ~sc, 0);
    acc(1, RX, 8'h03, 0);
    acc(0, SC, 0, sc);
    acc(0, RX, 0, 8'h00);
    clk_on <= 0;
    repeat (6) @(posedge ref_clk);
    acc(1, EV, 8'h00, 0);
    acc(0, EV, 0, 8'h03);
    acc(1, EV, 8'h02, 0);
    acc(0, EV, 0, 8'h01);
    clk_on <= 1;
    acc(1, EV, 8'h01, 0);
    acc(1, SC, ~sc, 0);
    acc(0, SC, 0, ~sc);
    $display("done: lock and loss");
    acc(1, HL, 8'h01, 0);
    acc(1, EV, 8'h01, 0);
    acc(1, EV, 8'h01, 0);
    acc(0, EV, 0, 8'h00);
    acc(0, HL, 0, 8'h01);
    acc(1, SC, sc, 0);
    chk({7'h00, write_blocked}, 8'h01);
    acc(0, SC, 0, ~sc);
    acc(0, 8'h30, 0, 8'h00);
    @(posedge ref_clk);
    sys_rst <= 1;
    @(posedge ref_clk);
    sys_rst <= 0;
    acc(1, SC, sc, 0);
    acc(0, SC, 0, sc);
    chk({7'h00, write_blocked}, 8'h00);
    $display("done: hard lock");
    repeat (2) @(posedge ref_clk);
    chk(8'(q.size()), 8'h00);
    results();
  end
  task results;
    $display("errors %0d of %0d checks", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
endmodule
bind lwr_regs lwr_regs_checker #(.NUM_INPUTS(NUM_INPUTS)) u_lwr_regs_checker (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .loss_detect(loss_detect),
  .input_self_bias_en(input_self_bias_en), .input_term_en(input_term_en),
  .write_blocked(write_blocked), .ctrl_scratch(ctrl_scratch));
